// ===== design/cgi_pkg.sv
package cgi_pkg;

  // ***************************************************
  // access decode of the identification register
  // ***************************************************
  localparam logic [3:0] CGI_CRN_ID     = 4'h0;
  localparam logic [2:0] CGI_OPC1_ID    = 3'h0;
  localparam logic [3:0] CGI_CRM_ID     = 4'h0;
  localparam logic [2:0] CGI_OPC2_CTYPE = 3'h1;

  // ***************************************************
  // description word layout
  // ***************************************************
  localparam int CGI_RSV_LSB   = 29;
  localparam int CGI_CTYPE_LSB = 25;
  localparam int CGI_SPLIT_BIT = 24;
  localparam int CGI_DGEO_LSB  = 12;
  localparam int CGI_IGEO_LSB  = 0;
  localparam int CGI_GEO_W     = 12;

  // geometry field layout
  localparam int CGI_GEO_P_BIT     = 11;
  localparam int CGI_GEO_RSV_BIT   = 10;
  localparam int CGI_GEO_SIZE_LSB  = 6;
  localparam int CGI_GEO_ASSOC_LSB = 3;
  localparam int CGI_GEO_M_BIT     = 2;
  localparam int CGI_GEO_LEN_LSB   = 0;

  // ***************************************************
  // cache kind codes
  // ***************************************************
  localparam logic [3:0] CGI_CT_WT       = 4'h0;
  localparam logic [3:0] CGI_CT_WB_RDBLK = 4'h1;
  localparam logic [3:0] CGI_CT_WB_MAINT = 4'h2;
  localparam logic [3:0] CGI_CT_LOCK_A   = 4'h6;
  localparam logic [3:0] CGI_CT_LOCK_B   = 4'h7;
  localparam logic [3:0] CGI_CT_LOCK_C   = 4'hE;
  localparam logic [3:0] CGI_CT_LOCK_D   = 4'h5;

  // line length, size and associativity codes
  localparam logic [1:0] CGI_LEN_2W      = 2'h0;
  localparam logic [1:0] CGI_LEN_4W      = 2'h1;
  localparam logic [1:0] CGI_LEN_8W      = 2'h2;
  localparam logic [1:0] CGI_LEN_16W     = 2'h3;
  localparam logic [3:0] CGI_SIZE_MAX    = 4'h8;
  localparam logic [2:0] CGI_ASSOC_ABSENT = 3'h0;

  // ***************************************************
  // implemented cache parameters (index 1 data, 0 instruction)
  // ***************************************************
  localparam logic [3:0] CGI_IMP_CTYPE   = CGI_CT_WB_MAINT;
  localparam logic       CGI_IMP_SPLIT   = 1'b1;
  localparam logic [1:0] CGI_IMP_PRESENT = 2'h3;
  localparam logic [1:0] CGI_IMP_RESTRICT = 2'h0;
  localparam logic [7:0] CGI_IMP_SIZE    = 8'h55;
  localparam logic [5:0] CGI_IMP_ASSOC   = 6'h12;
  localparam logic [1:0] CGI_IMP_MULT    = 2'h0;
  localparam logic [3:0] CGI_IMP_LEN     = 4'hA;

endpackage

// ===== design/cgi_geom_field.sv
`timescale 1ns/1ps

// builds one 12-bit geometry field, forcing the absent encoding when needed
module cgi_geom_field
  import cgi_pkg::*;
(
  // cache parameters
  input  wire logic        present,
  input  wire logic        restrict_pg,
  input  wire logic [3:0]  size_code,
  input  wire logic [2:0]  assoc_code,
  input  wire logic        mult,
  input  wire logic [1:0]  len_code,
  // encoded field
  output wire logic [11:0] field
);

  wire logic        mult_ok;
  wire logic [11:0] field_present;
  wire logic [11:0] field_absent;

  // direct mapped never carries the multiplier, else it would read as absent
  assign mult_ok       = (assoc_code == CGI_ASSOC_ABSENT) ? 1'b0 : mult;
  // reserved bit 10 always zero
  assign field_present = {restrict_pg, 1'b0, size_code, assoc_code, mult_ok, len_code};
  assign field_absent  = {1'b0, 1'b0, 4'h0, CGI_ASSOC_ABSENT, 1'b1, 2'h0};
  assign field         = present ? field_present : field_absent;

endmodule

// ===== design/cgi_access_check.sv
`timescale 1ns/1ps

// decodes one coprocessor access against the identification register
module cgi_access_check
  import cgi_pkg::*;
(
  // access request
  input  wire logic       req,
  input  wire logic       wr,
  input  wire logic [3:0] crn,
  input  wire logic [2:0] opc1,
  input  wire logic [3:0] crm,
  input  wire logic [2:0] opc2,
  input  wire logic       priv,
  // decision
  output wire logic       hit,
  output wire logic       undef
);

  wire logic addr_match;

  assign addr_match = (crn == CGI_CRN_ID) && (opc1 == CGI_OPC1_ID) &&
                      (crm == CGI_CRM_ID) && (opc2 == CGI_OPC2_CTYPE);
  // read only, privileged only; everything else is undefined
  assign hit   = req && !wr && priv && addr_match;
  assign undef = req && !hit;

endmodule

// ===== design/cgi_cache_geometry.sv
`timescale 1ns/1ps

// Contract
// - reading register 0 with secondary opcode 1 returns the read-only description word
// - the register answers only to accesses made in a privileged mode
// - an access to any unimplemented register is undefined, returning no data
// - word: bits 31-29 zero, kind 28-25, split 24, data 23-12, instruction 11-0
// - split is 1 for separate caches; 0 means both geometry fields are identical
// - kind 0000 write-through, 0001 read-block clean, 0010 maintenance clean, no lockdown
// - lockdown kinds: 0110 format A, 0111 B, 1110 C, 0101 D
// - geometry: page flag 11, bit 10 zero, size 9-6, assoc 5-3, mult 2, len 1-0
// - page flag is 1 when remapping virtual bits 13:12 is restricted, else 0
// - size codes 0 to 8 give 0.5KB to 128KB, times 1.5 with multiplier
// - length code 00 two words, 01 four, 10 eight, 11 sixteen words
// - assoc codes give 1 to 128 ways, 3 to 192 with multiplier except code 0
// - absent cache is assoc zero with multiplier one, overriding the other bits
module cgi_cache_geometry
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // coprocessor access request
  input  wire logic        cp_req,
  input  wire logic        cp_wr,
  input  wire logic [3:0]  cp_crn,
  input  wire logic [2:0]  cp_opc1,
  input  wire logic [3:0]  cp_crm,
  input  wire logic [2:0]  cp_opc2,
  input  wire logic        cp_priv,
  // coprocessor answer
  output logic             rsp_valid_q,
  output logic [31:0]      rsp_data_q,
  output logic             rsp_undef_q
);

  import cgi_pkg::*;

  // ***************************************************
  // geometry fields
  // ***************************************************
  logic [11:0] geo_field [2];
  logic [11:0] dgeo;
  logic [11:0] igeo;

  // one encoder per cache, index 1 data and 0 instruction
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_geo
      cgi_geom_field u_geo (
        .present     (CGI_IMP_PRESENT[gi]),
        .restrict_pg (CGI_IMP_RESTRICT[gi]),
        .size_code   (CGI_IMP_SIZE[gi*4 +: 4]),
        .assoc_code  (CGI_IMP_ASSOC[gi*3 +: 3]),
        .mult        (CGI_IMP_MULT[gi]),
        .len_code    (CGI_IMP_LEN[gi*2 +: 2]),
        .field       (geo_field[gi])
      );
    end
  endgenerate

  // a unified cache repeats the data field in the instruction slot
  assign dgeo = geo_field[1];
  assign igeo = CGI_IMP_SPLIT ? geo_field[0] : geo_field[1];

  // ***************************************************
  // description word
  // ***************************************************
  logic [31:0] word_d;
  logic [31:0] word_q;

  // fixed layout, top three bits zero
  assign word_d = {3'h0, CGI_IMP_CTYPE, CGI_IMP_SPLIT, dgeo, igeo};

  // reloaded from the fixed parameters on every edge, so it cannot drift after reset
  always_ff @(posedge clk)
  begin
    word_q <= word_d;
  end

  // ***************************************************
  // access decode and answer
  // ***************************************************
  logic acc_hit;
  logic acc_undef;

  cgi_access_check u_acc (
    .req   (cp_req),
    .wr    (cp_wr),
    .crn   (cp_crn),
    .opc1  (cp_opc1),
    .crm   (cp_crm),
    .opc2  (cp_opc2),
    .priv  (cp_priv),
    .hit   (acc_hit),
    .undef (acc_undef)
  );

  logic [31:0] rsp_data_d;

  // data only on a legal read, zero otherwise
  assign rsp_data_d = acc_hit ? word_q : 32'h0;

  // one-cycle answer to each request
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rsp_valid_q <= 1'b0;
      rsp_undef_q <= 1'b0;
      rsp_data_q  <= 32'h0;
    end
    else
    begin
      rsp_valid_q <= acc_hit;
      rsp_undef_q <= acc_undef;
      rsp_data_q  <= rsp_data_d;
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  logic        reset_done_q;

  // marks that a reset has been seen; stays set afterwards
  always_ff @(posedge clk)
  begin
    reset_done_q <= reset_done_q || !rst_n;
  end

  read_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cp_req && !cp_wr && cp_priv && cp_crn == 4'h0 && cp_opc1 == 3'h0 &&
     cp_crm == 4'h0 && cp_opc2 == 3'h1)
    |=> (rsp_valid_q && !rsp_undef_q && rsp_data_q == word_q))
    else $error("legal read did not return the description word");

  user_refused_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cp_req && !cp_priv) |=> (rsp_undef_q && !rsp_valid_q && rsp_data_q == 32'h0))
    else $error("unprivileged access was not refused");

  unmapped_undef_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cp_req && (cp_wr || cp_opc2 != 3'h1 || cp_crn != 4'h0))
    |=> (rsp_undef_q && !rsp_valid_q))
    else $error("access to unimplemented register was not undefined");

  no_spurious_a: assert property (@(posedge clk) disable iff (!rst_n)
    !cp_req |=> (!rsp_valid_q && !rsp_undef_q))
    else $error("answer without a request");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    rsp_valid_q |-> (rsp_data_q[31:29] == 3'h0 && rsp_data_q[10] == 1'b0 &&
                     rsp_data_q[22] == 1'b0))
    else $error("reserved bits of the description word not zero");

  unified_same_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && !rsp_data_q[24]) |-> (rsp_data_q[23:12] == rsp_data_q[11:0]))
    else $error("unified cache with differing geometry fields");

  kind_legal_a: assert property (@(posedge clk) disable iff (!rst_n)
    rsp_valid_q |-> (rsp_data_q[28:25] inside {4'h0, 4'h1, 4'h2, 4'h5, 4'h6,
                                              4'h7, 4'hE}))
    else $error("reserved cache kind code reported");

  kind_field_a: assert property (@(posedge clk) disable iff (!rst_n)
    rsp_valid_q |-> (rsp_data_q[28:25] == CGI_IMP_CTYPE &&
                     rsp_data_q[24] == CGI_IMP_SPLIT))
    else $error("kind or split field differs from the implementation");

  size_legal_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && !(rsp_data_q[5:3] == 3'h0 && rsp_data_q[2]))
    |-> (rsp_data_q[9:6] <= 4'h8))
    else $error("instruction cache size code out of range");

  direct_no_mult_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && CGI_IMP_PRESENT[1]) |-> !(rsp_data_q[17:15] == 3'h0 && rsp_data_q[14]))
    else $error("present data cache reported as absent");

  absent_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && !CGI_IMP_PRESENT[0] && CGI_IMP_SPLIT)
    |-> (rsp_data_q[5:3] == 3'h0 && rsp_data_q[2] == 1'b1))
    else $error("absent instruction cache not encoded as absent");

  page_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    rsp_valid_q |-> (rsp_data_q[23] == (CGI_IMP_PRESENT[1] & CGI_IMP_RESTRICT[1])))
    else $error("page restriction flag differs from the implementation");

  word_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    reset_done_q |-> ($stable(word_q) && word_q == word_d))
    else $error("description word changed after reset");

  back_to_back_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cp_req ##1 cp_req) |-> ##1 (rsp_valid_q || rsp_undef_q) [*1])
    else $error("back to back requests lost an answer");

  one_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(rsp_valid_q && rsp_undef_q))
    else $error("both valid and undefined asserted");

  // ***************************************************
  // named fields of the answer, watched by the checks below
  // ***************************************************
  logic [2:0]  ans_rsv;
  logic [3:0]  ans_kind;
  logic        ans_split;
  logic [11:0] ans_dgeo;
  logic [11:0] ans_igeo;
  logic        d_absent;
  logic        i_absent;

  // slices of the registered word at their fixed positions
  assign ans_rsv   = rsp_data_q[CGI_RSV_LSB +: 3];
  assign ans_kind  = rsp_data_q[CGI_CTYPE_LSB +: 4];
  assign ans_split = rsp_data_q[CGI_SPLIT_BIT];
  assign ans_dgeo  = rsp_data_q[CGI_DGEO_LSB +: CGI_GEO_W];
  assign ans_igeo  = rsp_data_q[CGI_IGEO_LSB +: CGI_GEO_W];

  // absent marker: associativity zero together with the multiplier
  assign d_absent = (ans_dgeo[CGI_GEO_ASSOC_LSB +: 3] == CGI_ASSOC_ABSENT) &&
                    ans_dgeo[CGI_GEO_M_BIT];
  assign i_absent = (ans_igeo[CGI_GEO_ASSOC_LSB +: 3] == CGI_ASSOC_ABSENT) &&
                    ans_igeo[CGI_GEO_M_BIT];

  // ***************************************************
  // answer framing checks
  // ***************************************************
  undef_no_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    rsp_undef_q |-> (rsp_data_q == 32'h0))
    else $error("undefined answer carried data");

  idle_no_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rsp_valid_q |-> (rsp_data_q == 32'h0))
    else $error("data shown without a valid read");

  valid_has_req_a: assert property (@(posedge clk) disable iff (!rst_n)
    rsp_valid_q |-> $past(cp_req))
    else $error("valid answer without a request");

  undef_has_req_a: assert property (@(posedge clk) disable iff (!rst_n)
    rsp_undef_q |-> $past(cp_req))
    else $error("undefined answer without a request");

  write_refused_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cp_req && cp_wr) |=> (rsp_undef_q && !rsp_valid_q && rsp_data_q == 32'h0))
    else $error("write to the read-only word was not undefined");

  reset_quiet_a: assert property (@(posedge clk)
    !rst_n |=> (!rsp_valid_q && !rsp_undef_q && rsp_data_q == 32'h0))
    else $error("answer shown after a reset edge");

  // ***************************************************
  // field checks: reserved bits, data size range, and fields against the implemented parameters
  // ***************************************************
  geo_rsv_a: assert property (@(posedge clk) disable iff (!rst_n)
    rsp_valid_q |-> (ans_dgeo[CGI_GEO_RSV_BIT] == 1'b0 &&
                     ans_igeo[CGI_GEO_RSV_BIT] == 1'b0 && ans_rsv == 3'h0))
    else $error("reserved geometry bit not zero");

  dsize_legal_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && !d_absent) |-> (ans_dgeo[CGI_GEO_SIZE_LSB +: 4] <= CGI_SIZE_MAX))
    else $error("data cache size code out of range");

  dsize_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && CGI_IMP_PRESENT[1])
    |-> (ans_dgeo[CGI_GEO_SIZE_LSB +: 4] == CGI_IMP_SIZE[7:4]))
    else $error("data cache size code differs from the implementation");

  isize_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && CGI_IMP_SPLIT && CGI_IMP_PRESENT[0])
    |-> (ans_igeo[CGI_GEO_SIZE_LSB +: 4] == CGI_IMP_SIZE[3:0]))
    else $error("instruction cache size code differs from the implementation");

  dlen_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && CGI_IMP_PRESENT[1])
    |-> (ans_dgeo[CGI_GEO_LEN_LSB +: 2] == CGI_IMP_LEN[3:2]))
    else $error("data cache line length differs from the implementation");

  ilen_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && CGI_IMP_SPLIT && CGI_IMP_PRESENT[0])
    |-> (ans_igeo[CGI_GEO_LEN_LSB +: 2] == CGI_IMP_LEN[1:0]))
    else $error("instruction cache line length differs from the implementation");

  dassoc_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && CGI_IMP_PRESENT[1])
    |-> (ans_dgeo[CGI_GEO_ASSOC_LSB +: 3] == CGI_IMP_ASSOC[5:3]))
    else $error("data cache associativity differs from the implementation");

  iassoc_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && CGI_IMP_SPLIT && CGI_IMP_PRESENT[0])
    |-> (ans_igeo[CGI_GEO_ASSOC_LSB +: 3] == CGI_IMP_ASSOC[2:0]))
    else $error("instruction cache associativity differs from the implementation");

  dmult_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && CGI_IMP_PRESENT[1] && CGI_IMP_ASSOC[5:3] != CGI_ASSOC_ABSENT)
    |-> (ans_dgeo[CGI_GEO_M_BIT] == CGI_IMP_MULT[1]))
    else $error("data cache multiplier differs from the implementation");

  imult_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && CGI_IMP_SPLIT && CGI_IMP_PRESENT[0] &&
     CGI_IMP_ASSOC[2:0] != CGI_ASSOC_ABSENT)
    |-> (ans_igeo[CGI_GEO_M_BIT] == CGI_IMP_MULT[0]))
    else $error("instruction cache multiplier differs from the implementation");

  ipage_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && CGI_IMP_SPLIT)
    |-> (ans_igeo[CGI_GEO_P_BIT] == (CGI_IMP_PRESENT[0] & CGI_IMP_RESTRICT[0])))
    else $error("instruction page restriction flag differs from the implementation");

  present_i_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && CGI_IMP_SPLIT && CGI_IMP_PRESENT[0]) |-> !i_absent)
    else $error("present instruction cache reported as absent");

  dabsent_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid_q && !CGI_IMP_PRESENT[1]) |-> d_absent)
    else $error("absent data cache not encoded as absent");

  kind_split_a: assert property (@(posedge clk) disable iff (!rst_n)
    rsp_valid_q |-> (ans_split == CGI_IMP_SPLIT && ans_kind == CGI_IMP_CTYPE))
    else $error("split flag or kind code differs from the implementation");

endmodule

// ===== bench/cgi_core_model.sv
`timescale 1ns/1ps

// ***************************************************
// processor core side: issues coprocessor accesses
// ***************************************************
module cgi_core_model
(
  // clock
  input  wire logic  clk,
  // coprocessor access request
  output logic       cp_req,
  output logic       cp_wr,
  output logic [3:0] cp_crn,
  output logic [2:0] cp_opc1,
  output logic [3:0] cp_crm,
  output logic [2:0] cp_opc2,
  output logic       cp_priv
);
  // idle request at time zero
  initial
  begin
    cp_req  = 1'b0;
    cp_wr   = 1'b0;
    cp_crn  = 4'hF;
    cp_opc1 = 3'h7;
    cp_crm  = 4'hF;
    cp_opc2 = 3'h7;
    cp_priv = 1'b0;
  end

  // present one access for the next edge; a read, or a write when wr is set
  task drive(input logic wr, input logic [3:0] crn, input logic [2:0] opc1,
             input logic [3:0] crm, input logic [2:0] opc2, input logic priv);
    @(posedge clk);
    cp_req  <= 1'b1;
    cp_wr   <= wr;
    cp_crn  <= crn;
    cp_opc1 <= opc1;
    cp_crm  <= crm;
    cp_opc2 <= opc2;
    cp_priv <= priv;
  endtask

  // drop the strobe; released qualifiers flip so stale values never look valid
  task idle();
    @(posedge clk);
    cp_req  <= 1'b0;
    cp_wr   <= ~cp_wr;
    cp_crn  <= ~cp_crn;
    cp_opc1 <= ~cp_opc1;
    cp_crm  <= ~cp_crm;
    cp_opc2 <= ~cp_opc2;
    cp_priv <= ~cp_priv;
  endtask
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import cgi_pkg::*;
  // ***************************************************
  // clock, reset, wires and counters
  // ***************************************************
  logic        clk;
  logic        rst_n;
  logic        cp_req, cp_wr, cp_priv;
  logic [3:0]  cp_crn, cp_crm;
  logic [2:0]  cp_opc1, cp_opc2;
  logic        rsp_valid_q, rsp_undef_q;
  logic [31:0] rsp_data_q, exp_word, got_word;
  logic [11:0] geo_d, geo_i, geo;
  logic [15:0] bad [7] = '{16'h8003, 16'h0002, 16'h0001, 16'h0803, 16'h0103, 16'h0013, 16'h0005};
  int          fails = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  // expected word built from the implemented parameters; absent cache is 0x004
  assign geo_d = CGI_IMP_PRESENT[1] ? {CGI_IMP_RESTRICT[1], 1'b0, CGI_IMP_SIZE[7:4],
                   CGI_IMP_ASSOC[5:3], CGI_IMP_MULT[1], CGI_IMP_LEN[3:2]} : 12'h004;
  assign geo_i = CGI_IMP_PRESENT[0] ? {CGI_IMP_RESTRICT[0], 1'b0, CGI_IMP_SIZE[3:0],
                   CGI_IMP_ASSOC[2:0], CGI_IMP_MULT[0], CGI_IMP_LEN[1:0]} : 12'h004;
  assign exp_word = {3'h0, CGI_IMP_CTYPE, CGI_IMP_SPLIT, geo_d, CGI_IMP_SPLIT ? geo_i : geo_d};

  // clock generator, 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  cgi_cache_geometry cgi_cache_geometry_inst (.clk(clk), .rst_n(rst_n), .cp_req(cp_req),
    .cp_wr(cp_wr), .cp_crn(cp_crn), .cp_opc1(cp_opc1), .cp_crm(cp_crm), .cp_opc2(cp_opc2),
    .cp_priv(cp_priv), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
    .rsp_undef_q(rsp_undef_q));
  cgi_core_model cgi_core_model_inst (.clk(clk), .cp_req(cp_req), .cp_wr(cp_wr),
    .cp_crn(cp_crn), .cp_opc1(cp_opc1), .cp_crm(cp_crm), .cp_opc2(cp_opc2), .cp_priv(cp_priv));

  // ***************************************************
  // checking helpers
  // ***************************************************
  task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task expect_rsp(input logic v, input logic u, input logic [31:0] d);
    #1;
    check({30'h0, rsp_valid_q, rsp_undef_q}, {30'h0, v, u}, "answer flags");
    check(rsp_data_q, d, "answer data");
  endtask

  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  // a legal read under reset gets no answer; release after six edges
  task test_reset();
    cgi_core_model_inst.drive(1'b0, 4'h0, 3'h0, 4'h0, 3'h1, 1'b1);
    repeat (4) @(posedge clk);
    expect_rsp(1'b0, 1'b0, 32'h0);
    cgi_core_model_inst.idle();
    rst_n <= 1'b1;
  endtask

  // single privileged read returns the word for exactly one cycle
  task test_read();
    cgi_core_model_inst.drive(1'b0, 4'h0, 3'h0, 4'h0, 3'h1, 1'b1);
    cgi_core_model_inst.idle();
    expect_rsp(1'b1, 1'b0, exp_word);
    got_word = rsp_data_q;
    @(posedge clk);
    expect_rsp(1'b0, 1'b0, 32'h0);
  endtask

  // writes, user mode and a neighbouring address in each field are undefined
  task test_refused();
    foreach (bad[k])
    begin
      cgi_core_model_inst.drive(bad[k][15], bad[k][14:11], bad[k][10:8], bad[k][7:4],
                                bad[k][3:1], bad[k][0]);
      cgi_core_model_inst.idle();
      expect_rsp(1'b0, 1'b1, 32'h0);
    end
  endtask

  // read, refused access, read on consecutive edges
  task test_back2back();
    cgi_core_model_inst.drive(1'b0, 4'h0, 3'h0, 4'h0, 3'h1, 1'b1);
    cgi_core_model_inst.drive(1'b0, 4'h0, 3'h0, 4'h0, 3'h1, 1'b0);
    expect_rsp(1'b1, 1'b0, exp_word);
    cgi_core_model_inst.drive(1'b0, 4'h0, 3'h0, 4'h0, 3'h1, 1'b1);
    expect_rsp(1'b0, 1'b1, 32'h0);
    cgi_core_model_inst.idle();
    expect_rsp(1'b1, 1'b0, exp_word);
  endtask

  // legality of every field of the word actually read
  task test_fields();
    check({29'h0, got_word[31:29]}, 32'h0, "reserved top bits");
    check({31'h0, got_word[28:25] inside {4'h0, 4'h1, 4'h2, 4'h6, 4'h7, 4'hE, 4'h5}}, 32'h1,
          "kind code");
    if (got_word[24] === 1'b0)
      check({20'h0, got_word[23:12]}, {20'h0, got_word[11:0]}, "unified fields");
    for (int k = 0; k < 2; k++)
    begin
      geo = got_word[k*12 +: 12];
      check({31'h0, geo[10]}, 32'h0, "geometry reserved bit");
      if (geo[5:3] === 3'h0 && geo[2] === 1'b1)
        check({20'h0, geo}, 32'h4, "absent field");
      else
        check({31'h0, geo[9:6] <= 4'h8}, 32'h1, "size code");
    end
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    test_reset();
    test_read();
    test_refused();
    test_back2back();
    test_fields();
    tally_and_finish();
  end
endmodule
